// ### logic/axis_correction_sync_start.sv
/*
  One axis of start sequencing: correction pulses before a start, two
  vibration suppression pulses after a normal end outside timer mode, and a start held until
  chosen axes stop. Assumes all inputs are synchronous to core_clk, that
  startSpeedTick pulses at the start speed, and that genDone/genAbort are
  one-cycle pulses from the pulse generator while it runs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "acss_defs.svh"
module axis_correction_sync_start
  import acss_pkg::*;
#(
  parameter logic [1:0] OWN_AXIS = 2'h0
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic        startCmd,
  input  wire logic        opDirNeg,
  input  wire logic        opCircular,
  input  wire logic        opTimerMode,
  input  wire logic        startSpeedTick,
  input  wire logic        genDone,
  input  wire logic        genAbort,
  input  wire logic [3:0]  axisBusy,
  output logic             genStart,
  output logic             pulseOut,
  output logic             pulseDirNeg,
  output logic      [3:0]  ctrCountCorrection,
  output logic      [3:0]  operatingStatus
);

  acss_regs_t stateReg;
  acss_regs_t stateNext;

  // Clock count of one suppression pulse cycle
  function automatic logic [20:0] cyc32(input logic [15:0] v);
    cyc32 = {v, 5'h00} - 21'h000001;
  endfunction

  // Whether a start needs correction pulses first
  function automatic logic needCorr(input acss_regs_t s);
    logic [1:0] sel;
    sel = s.corr[`ACSS_SEL_MSB:`ACSS_SEL_LSB];
    needCorr = 1'b0;
    if (!s.newCirc && s.corr[`ACSS_AMT_MSB:0] != 12'h000) begin
      if (sel == `ACSS_SEL_BKL)
        needCorr = (s.newDir != s.lastDir);
      else if (sel == `ACSS_SEL_SLIP)
        needCorr = 1'b1;
    end
  endfunction

  logic [1:0]  corrSel;
  logic [15:0] rtVal;
  logic [15:0] ftVal;
  logic [3:0]  selAxes;
  logic [3:0]  ownBit;
  logic [3:0]  othersMask;
  logic [3:0]  countMask;
  logic [3:0]  stopVec;
  logic        ownStop;
  logic        stopEvent;
  logic        othersClear;
  logic        syncMode;

  // Field views and stop bookkeeping shared by the sequencer
  assign corrSel     = stateReg.corr[`ACSS_SEL_MSB:`ACSS_SEL_LSB];
  assign rtVal       = stateReg.vib[`ACSS_RT_MSB:`ACSS_RT_LSB];
  assign ftVal       = stateReg.vib[`ACSS_FT_MSB:`ACSS_FT_LSB];
  assign selAxes     = stateReg.mode[`ACSS_MAX_MSB:`ACSS_MAX_LSB];
  assign syncMode    = stateReg.mode[`ACSS_MSY_MSB:`ACSS_MSY_LSB] == `ACSS_MSY_STOP;
  assign ownBit      = 4'h1 << OWN_AXIS;
  assign othersMask  = selAxes & ~ownBit;
  // Own stop counts only when the own-axis option is set
  assign countMask   = stateReg.env2[`ACSS_OWN_AXIS_STOP_COUNTS_BIT] ? selAxes : othersMask;
  assign ownStop     = (stateReg.st == ST_RUN) && (genDone || genAbort);
  assign stopVec     = (stateReg.busyPrev & ~axisBusy & ~ownBit) | (ownStop ? ownBit : 4'h0);
  // A stop after a start satisfies the wait even if others never moved
  assign stopEvent   = |(stopVec & countMask);
  assign othersClear = ~|(axisBusy & othersMask);

  // Next-state logic: register file and sequencer
  always_comb begin
    logic go;
    logic queue;
    go = 1'b0;
    // In sync mode, a start in a busy phase other than correction is queued behind it
    queue = startCmd && syncMode && stateReg.st != ST_IDLE && stateReg.st != ST_WAIT
            && stateReg.st != ST_CORR;
    stateNext = stateReg;
    stateNext.pulse = 1'b0;
    stateNext.genStart = 1'b0;
    stateNext.ctrEn = 4'h0;
    stateNext.busyPrev = axisBusy;
    stateNext.rdData = `ACSS_RST_WORD;

    // Register writes
    if (regWr) begin
      case (regAddr)
        `ACSS_OFF_ENV2:   stateNext.env2 = regWrData;
        `ACSS_OFF_CTRENV: stateNext.ctrEnv = regWrData;
        `ACSS_OFF_CORR:   stateNext.corr = regWrData;
        `ACSS_OFF_VIB:    stateNext.vib = regWrData;
        `ACSS_OFF_MODE:   stateNext.mode = regWrData;
        default:          stateNext.env2 = stateNext.env2;
      endcase
    end

    // Register reads, answered in the next cycle; holes read zero
    if (regRd) begin
      case (regAddr)
        `ACSS_OFF_ENV2:   stateNext.rdData = stateReg.env2;
        `ACSS_OFF_CTRENV: stateNext.rdData = stateReg.ctrEnv;
        `ACSS_OFF_CORR:   stateNext.rdData = stateReg.corr;
        `ACSS_OFF_VIB:    stateNext.rdData = stateReg.vib;
        `ACSS_OFF_MODE:   stateNext.rdData = stateReg.mode;
        `ACSS_OFF_STATUS: stateNext.rdData = {25'h0000000, stateReg.stopSeen,
                                              stateReg.syncPend, stateReg.lastDir,
                                              operatingStatus};
        default:          stateNext.rdData = `ACSS_RST_WORD;
      endcase
    end

    // Operation attributes are caught with the start command
    // Never during correction: its pulses must keep the direction they began with
    if ((startCmd && stateReg.st == ST_IDLE) || queue) begin
      stateNext.newDir = opDirNeg;
      stateNext.newCirc = opCircular;
      stateNext.newTimer = opTimerMode;
    end

    // A queued start restarts the stop bookkeeping
    if (queue) begin
      stateNext.syncPend = 1'b1;
      stateNext.stopSeen = 1'b0;
    end

    case (stateReg.st)
      ST_IDLE: begin
        if (startCmd) begin
          if (syncMode) begin
            stateNext.st = ST_WAIT;
            stateNext.stopSeen = 1'b0;
          end else begin
            go = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        // Release needs a counted stop and no other selected axis still busy
        if ((stateReg.stopSeen || stopEvent) && othersClear) begin
          go = 1'b1;
          stateNext.stopSeen = 1'b0;
          stateNext.syncPend = 1'b0;
        end
      end
      ST_CORR: begin
        // One correction pulse per start-speed tick, in the new direction
        if (startSpeedTick) begin
          stateNext.pulse = 1'b1;
          stateNext.pulseDir = stateReg.newDir;
          stateNext.ctrEn = stateReg.ctrEnv[`ACSS_CU_MSB:`ACSS_CU_LSB];
          stateNext.corrCnt = stateReg.corrCnt + 12'h001;
          if (stateReg.corrCnt == stateReg.corr[`ACSS_AMT_MSB:0] - 12'h001) begin
            stateNext.genStart = 1'b1;
            stateNext.st = ST_RUN;
            stateNext.lastDir = stateReg.newDir;
            stateNext.curTimer = stateReg.newTimer;
          end
        end
      end
      ST_RUN: begin
        if (genAbort) begin
          stateNext.st = stateNext.syncPend ? ST_WAIT : ST_IDLE;
        end else if (genDone) begin
          stateNext.vibCnt = 21'h000000;
          if (!stateReg.curTimer && rtVal != 16'h0000 && ftVal != 16'h0000)
            stateNext.st = ST_VREV;
          else
            stateNext.st = stateNext.syncPend ? ST_WAIT : ST_IDLE;
        end
      end
      ST_VREV: begin
        stateNext.vibCnt = stateReg.vibCnt + 21'h000001;
        if (stateReg.vibCnt >= cyc32(rtVal)) begin
          stateNext.pulse = 1'b1;
          stateNext.pulseDir = ~stateReg.lastDir;
          stateNext.vibCnt = 21'h000000;
          stateNext.st = ST_VFWD;
        end
      end
      ST_VFWD: begin
        stateNext.vibCnt = stateReg.vibCnt + 21'h000001;
        if (stateReg.vibCnt >= cyc32(ftVal)) begin
          stateNext.pulse = 1'b1;
          stateNext.pulseDir = stateReg.lastDir;
          stateNext.st = stateNext.syncPend ? ST_WAIT : ST_IDLE;
        end
      end
      default: stateNext.st = ST_IDLE;
    endcase

    // Common launch: correction first when due, else start at once
    if (go) begin
      stateNext.corrCnt = 12'h000;
      if (needCorr(stateNext)) begin
        stateNext.st = ST_CORR;
      end else begin
        stateNext.st = ST_RUN;
        stateNext.genStart = 1'b1;
        stateNext.lastDir = stateNext.newDir;
        stateNext.curTimer = stateNext.newTimer;
      end
    end

    // Stops seen while a start is held are remembered; a stop in the
    // same cycle as a queuing start still counts, so the set wins
    if ((stateNext.syncPend || stateNext.st == ST_WAIT) && stopEvent)
      stateNext.stopSeen = 1'b1;
  end

  // State register; everything clears to zero except the state code
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateReg <= '0;
      stateReg.st <= ST_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Outputs straight from flip-flops, except the status decode
  assign regRdData = stateReg.rdData;
  assign genStart = stateReg.genStart;
  assign pulseOut = stateReg.pulse;
  assign pulseDirNeg = stateReg.pulseDir;
  assign ctrCountCorrection = stateReg.ctrEn;

  // Running covers correction and suppression too, so software sees busy
  always_comb begin
    case (stateReg.st)
      ST_IDLE: operatingStatus = `ACSS_CND_IDLE;
      ST_WAIT: operatingStatus = `ACSS_CND_WAIT;
      default: operatingStatus = `ACSS_CND_RUN;
    endcase
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_backlash_entry: assert property (
    (stateReg.st == ST_IDLE && startCmd && !syncMode && corrSel == `ACSS_SEL_BKL
     && !opCircular && opDirNeg != stateReg.lastDir
     && stateReg.corr[`ACSS_AMT_MSB:0] != 12'h000)
    |=> stateReg.st == ST_CORR)
    else $error("backlash correction not entered");

  a_no_circ_corr: assert property (
    stateReg.st == ST_CORR |-> !stateReg.newCirc)
    else $error("correction before circular operation");

  a_slip_entry: assert property (
    (stateReg.st == ST_IDLE && startCmd && !syncMode && corrSel == `ACSS_SEL_SLIP
     && !opCircular && stateReg.corr[`ACSS_AMT_MSB:0] != 12'h000)
    |=> stateReg.st == ST_CORR)
    else $error("slip correction not entered");

  // Starts that must go straight to the commanded operation
  a_dir_same_skip: assert property (
    (stateReg.st == ST_IDLE && startCmd && !syncMode && corrSel == `ACSS_SEL_BKL
     && opDirNeg == stateReg.lastDir)
    |=> stateReg.st != ST_CORR)
    else $error("backlash correction without direction change");

  a_sel_none_run: assert property (
    (stateReg.st == ST_IDLE && startCmd && !syncMode && corrSel == `ACSS_SEL_NONE)
    |=> stateReg.st == ST_RUN && genStart)
    else $error("select none did not start at once");

  a_amount_zero: assert property (
    (stateReg.st == ST_IDLE && startCmd && !syncMode
     && stateReg.corr[`ACSS_AMT_MSB:0] == 12'h000)
    |=> stateReg.st != ST_CORR)
    else $error("correction with zero amount");

  a_corr_dir: assert property (
    (pulseOut && $past(stateReg.st) == ST_CORR) |-> pulseDirNeg == $past(stateReg.newDir))
    else $error("correction pulse direction");

  a_ctr_quiet: assert property (
    (pulseOut && $past(stateReg.st) != ST_CORR) |-> ctrCountCorrection == 4'h0)
    else $error("suppression pulse counted as correction");

  a_ctr_gate: assert property (
    ctrCountCorrection != 4'h0 |-> pulseOut && $past(stateReg.st) == ST_CORR)
    else $error("counter enable outside correction pulse");

  a_corr_last: assert property (
    (stateReg.st == ST_CORR && startSpeedTick
     && stateReg.corrCnt == stateReg.corr[`ACSS_AMT_MSB:0] - 12'h001)
    |=> genStart && pulseOut && stateReg.st == ST_RUN)
    else $error("correction count not honoured");

  a_sel_none: assert property (
    (stateReg.st != ST_CORR ##1 stateReg.st == ST_CORR)
    |-> $past(corrSel) != `ACSS_SEL_NONE)
    else $error("correction with select none");

  a_vib_cause: assert property (
    (stateReg.st == ST_RUN && (genDone || genAbort)
     && (rtVal == 16'h0000 || ftVal == 16'h0000 || genAbort || stateReg.curTimer))
    |=> stateReg.st != ST_VREV)
    else $error("suppression without cause");

  a_timer_quiet: assert property (
    (stateReg.st == ST_RUN && genDone && stateReg.curTimer) |=> stateReg.st != ST_VREV)
    else $error("suppression after timer mode");

  a_abort_quiet: assert property (
    (stateReg.st == ST_RUN && genAbort) |=> stateReg.st != ST_VREV [*2])
    else $error("suppression after abort");

  a_rev_pulse: assert property (
    (stateReg.st == ST_VREV && stateReg.vibCnt == cyc32(rtVal))
    |=> pulseOut && pulseDirNeg == !stateReg.lastDir)
    else $error("reverse pulse timing");

  a_fwd_pulse: assert property (
    (stateReg.st == ST_VFWD && stateReg.vibCnt == cyc32(ftVal))
    |=> pulseOut && pulseDirNeg == stateReg.lastDir)
    else $error("forward pulse timing");

  a_wait_status: assert property (
    (stateReg.st == ST_IDLE && startCmd && syncMode)
    |=> operatingStatus == `ACSS_CND_WAIT)
    else $error("wait status missing");

  // Queued starts wait for the current work to finish
  a_sync_queue: assert property (
    (stateReg.st == ST_RUN && startCmd && syncMode) |=> stateReg.syncPend)
    else $error("start not queued");

  a_pend_release: assert property (
    (stateReg.st == ST_VFWD && stateReg.vibCnt >= cyc32(ftVal) && stateReg.syncPend)
    |=> stateReg.st == ST_WAIT)
    else $error("queued start lost after suppression");

  a_release_go: assert property (
    (stateReg.st == ST_WAIT && (stateReg.stopSeen || stopEvent) && othersClear)
    |=> stateReg.st == ST_RUN || stateReg.st == ST_CORR)
    else $error("wait not released");

  a_wait_hold: assert property (
    (stateReg.st == ST_WAIT && !othersClear) |=> stateReg.st == ST_WAIT)
    else $error("released while axis busy");

  a_own_ignored: assert property (
    (stateReg.st == ST_WAIT && !stateReg.stopSeen && !stopEvent)
    |=> stateReg.st == ST_WAIT)
    else $error("released without counted stop");

  c_corr: cover property (stateReg.st == ST_CORR ##1 genStart);
  c_vib: cover property (stateReg.st == ST_VFWD ##1 pulseOut);
  c_wait: cover property (stateReg.st == ST_WAIT ##1 stateReg.st == ST_RUN);
  c_slip: cover property (stateReg.st == ST_CORR && corrSel == `ACSS_SEL_SLIP);
  c_abort: cover property (stateReg.st == ST_RUN && genAbort);

endmodule
`default_nettype wire

// ### logic/acss_defs.svh
/*
  Constants of the axis start sequencer: register offsets, field positions,
  status codes. Assumes inclusion by bare name from the design files.
*/
`ifndef ACSS_DEFS_SVH
`define ACSS_DEFS_SVH
`define ACSS_OFF_ENV2    8'h00
`define ACSS_OFF_CTRENV  8'h04
`define ACSS_OFF_CORR    8'h08
`define ACSS_OFF_VIB     8'h0c
`define ACSS_OFF_MODE    8'h10
`define ACSS_OFF_STATUS  8'h14
`define ACSS_RST_WORD    32'h0000_0000
`define ACSS_AMT_MSB     11
`define ACSS_SEL_MSB     13
`define ACSS_SEL_LSB     12
`define ACSS_SEL_NONE    2'h0
`define ACSS_SEL_BKL     2'h1
`define ACSS_SEL_SLIP    2'h2
`define ACSS_CU_MSB      27
`define ACSS_CU_LSB      24
`define ACSS_RT_MSB      15
`define ACSS_RT_LSB      0
`define ACSS_FT_MSB      31
`define ACSS_FT_LSB      16
`define ACSS_MSY_MSB     19
`define ACSS_MSY_LSB     18
`define ACSS_MSY_STOP    2'h3
`define ACSS_MAX_MSB     23
`define ACSS_MAX_LSB     20
`define ACSS_OWN_AXIS_STOP_COUNTS_BIT    29
`define ACSS_VIB_SHIFT   5
`define ACSS_CND_IDLE    4'h0
`define ACSS_CND_RUN     4'h1
`define ACSS_CND_WAIT    4'h4
`endif

// ### logic/acss_pkg.sv
/*
  Types of the axis start sequencer: state encoding and the state record.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package acss_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT = 6'h02,
    ST_CORR = 6'h04,
    ST_RUN  = 6'h08,
    ST_VREV = 6'h10,
    ST_VFWD = 6'h20
  } acss_state_t;

  typedef struct packed {
    acss_state_t st;
    logic [31:0] env2;
    logic [31:0] ctrEnv;
    logic [31:0] corr;
    logic [31:0] vib;
    logic [31:0] mode;
    logic [11:0] corrCnt;
    logic [20:0] vibCnt;
    logic        lastDir;
    logic        newDir;
    logic        newCirc;
    logic        newTimer;
    logic        curTimer;
    logic        syncPend;
    logic        stopSeen;
    logic [3:0]  busyPrev;
    logic [31:0] rdData;
    logic        pulse;
    logic        pulseDir;
    logic        genStart;
    logic [3:0]  ctrEn;
  } acss_regs_t;
endpackage
`default_nettype wire

// ### dv/acss_motor_model.sv
/*
  Motor driver stand-in: counts command steps in each direction.
  Assumes steps are one-cycle strobes synchronous to core_clk and that the
  direction line is valid in the same cycle as the step.
*/
`timescale 1ns/10ps
`default_nettype none
module acss_motor_model (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic stepIn,
  input  wire logic dirNegIn,
  output var  int   posSteps,
  output var  int   negSteps
);
  // The driver latches direction with each step; unknown steps are not counted
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      posSteps <= 0;
      negSteps <= 0;
    end else if (stepIn === 1'h1) begin
      if (dirNegIn === 1'h1) begin
        negSteps <= negSteps + 1;
      end else begin
        posSteps <= posSteps + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/axis_correction_sync_start_bench.sv
/*
  Self-checking bench for the axis start sequencer: register port, correction,
  suppression and synchronous start. Assumes the design and the motor model
  are compiled first and that the axis is axis X (index 0).
*/
`timescale 1ns/10ps
`default_nettype none
`include "acss_defs.svh"
module axis_correction_sync_start_bench;
  logic        core_clk;
  logic        sys_rst;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        startCmd, opDirNeg, opCircular, opTimerMode;
  logic        startSpeedTick = 1'h0;
  logic        genDone, genAbort;
  logic [3:0]  axisBusy;
  logic        genStart, pulseOut, pulseDirNeg;
  logic [3:0]  ctrCountCorrection, operatingStatus;
  logic [3:0]  lastCtr = 4'h0;
  logic [1:0]  tickCnt = 2'h0;
  logic [31:0] rdv;
  int          posSteps, negSteps, cyc, doneCyc, lastPc, prevPc;
  int          nMismatch, numChecks, p0, n0, dp, dn, k;
  logic [31:0] cw [6] = '{32'h1002, 32'h1002, 32'h1002, 32'h2003, 32'h2003, 32'h0003};
  logic        dr [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1};
  logic        ci [6] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
  int          ex [6] = '{2, 0, 0, 3, 0, 0};

  axis_correction_sync_start i_axis_correction_sync_start (
    .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .startCmd(startCmd),
    .opDirNeg(opDirNeg), .opCircular(opCircular), .opTimerMode(opTimerMode),
    .startSpeedTick(startSpeedTick), .genDone(genDone), .genAbort(genAbort),
    .axisBusy(axisBusy), .genStart(genStart), .pulseOut(pulseOut),
    .pulseDirNeg(pulseDirNeg), .ctrCountCorrection(ctrCountCorrection),
    .operatingStatus(operatingStatus));

  acss_motor_model i_acss_motor_model (
    .core_clk(core_clk), .sys_rst(sys_rst), .stepIn(pulseOut), .dirNegIn(pulseDirNeg),
    .posSteps(posSteps), .negSteps(negSteps));

  // 50 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  // Start-speed tick every fourth cycle, cycle count and pulse times
  always @(posedge core_clk) begin
    tickCnt <= tickCnt + 2'h1;
    startSpeedTick <= (tickCnt == 2'h3);
    cyc <= cyc + 1;
    if (genDone) begin
      doneCyc <= cyc;
    end
    if (pulseOut === 1'h1) begin
      prevPc <= lastPc;
      lastPc <= cyc;
      lastCtr <= ctrCountCorrection;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge core_clk);
    regRd <= 1'h0;
    @(negedge core_clk);
    d = regRdData;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Step counts since the previous snapshot
  task automatic snap();
    dp = posSteps - p0;
    dn = negSteps - n0;
    p0 = posSteps;
    n0 = negSteps;
  endtask

  task automatic launch(input logic dneg, input logic circ, input logic tmr);
    @(posedge core_clk);
    snap();
    startCmd <= 1'h1;
    opDirNeg <= dneg;
    opCircular <= circ;
    opTimerMode <= tmr;
    @(posedge core_clk);
    startCmd <= 1'h0;
  endtask

  // Bounded wait for the begin strobe; the last correction step lands one edge later
  task automatic await_go();
    int i;
    @(negedge core_clk);
    for (i = 0; i < 400 && genStart !== 1'h1; i++) begin
      @(negedge core_clk);
    end
    chk("genStart", 32'h1, {31'h0, genStart});
    @(posedge core_clk);
    #1;
    snap();
  endtask

  task automatic pulse_end(input logic ab);
    @(posedge core_clk);
    genDone <= ~ab;
    genAbort <= ab;
    @(posedge core_clk);
    genDone <= 1'h0;
    genAbort <= 1'h0;
  endtask

  // Long enough for both suppression steps at the cycle values used here
  task automatic finish(input logic ab);
    pulse_end(ab);
    repeat (200) @(posedge core_clk);
    #1;
    snap();
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {regWr, regRd, startCmd, opDirNeg, opCircular, opTimerMode, genDone, genAbort} = 8'h00;
    regAddr = 8'h00;
    regWrData = 32'h0;
    axisBusy = 4'h0;
    {nMismatch, numChecks, p0, n0} = '0;
    sys_rst = 1'h1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'h0;
    rd(`ACSS_OFF_CORR, rdv);
    chk("reset correction_setup", `ACSS_RST_WORD, rdv);
    wr(`ACSS_OFF_CTRENV, 32'h0500_0000);
    wr(`ACSS_OFF_VIB, 32'h0002_0000);
    wr(`ACSS_OFF_CORR, 32'h0000_1fff);
    rd(`ACSS_OFF_CORR, rdv);
    chk("correction_setup", 32'h0000_1fff, rdv);
    rd(8'h20, rdv);
    chk("unmapped", 32'h0, rdv);
    wr(`ACSS_OFF_STATUS, 32'hffff_ffff);
    rd(`ACSS_OFF_STATUS, rdv);
    chk("axis_status", 32'h0, rdv);
    $display("test registers done");
    // Each row: select and amount, direction, circular, expected steps
    for (k = 0; k < 6; k++) begin
      wr(`ACSS_OFF_CORR, cw[k]);
      launch(dr[k], ci[k], 1'h0);
      await_go();
      chk("neg correction", dr[k] ? ex[k] : 0, dn);
      chk("pos correction", dr[k] ? 0 : ex[k], dp);
      if (k == 0) begin
        chk("counter enables", 32'h5, {28'h0, lastCtr});
      end
      finish(1'h0);
      chk("suppression steps", 32'h0, dp + dn);
    end
    $display("test correction done");
    // Cycle values would be tuned on the machine; small ones keep the run short
    wr(`ACSS_OFF_CORR, 32'h0);
    wr(`ACSS_OFF_VIB, 32'h0002_0001);
    launch(1'h0, 1'h0, 1'h0);
    await_go();
    finish(1'h0);
    chk("reverse step", 32'h1, dn);
    chk("forward step", 32'h1, dp);
    chk("reverse delay", 32'd33, prevPc - doneCyc);
    chk("forward delay", 32'd64, lastPc - prevPc);
    launch(1'h0, 1'h0, 1'h1);
    await_go();
    finish(1'h0);
    chk("timer steps", 32'h0, dp + dn);
    launch(1'h0, 1'h0, 1'h0);
    await_go();
    finish(1'h1);
    chk("abort steps", 32'h0, dp + dn);
    $display("test suppression done");
    // Y and Z selected; Y runs and stops, Z never starts
    wr(`ACSS_OFF_VIB, 32'h0);
    wr(`ACSS_OFF_MODE, 32'h006c_0000);
    axisBusy <= 4'h2;
    launch(1'h0, 1'h0, 1'h0);
    rd(`ACSS_OFF_STATUS, rdv);
    chk("waiting status", 32'h4, rdv & 32'hf);
    chk("status port", 32'h4, {28'h0, operatingStatus});
    @(posedge core_clk);
    axisBusy <= 4'h0;
    await_go();
    finish(1'h0);
    // Own axis selected, own stop counted
    wr(`ACSS_OFF_ENV2, 32'h2000_0000);
    wr(`ACSS_OFF_MODE, 32'h0);
    launch(1'h0, 1'h0, 1'h0);
    await_go();
    wr(`ACSS_OFF_MODE, 32'h001c_0000);
    launch(1'h0, 1'h0, 1'h0);
    pulse_end(1'h0);
    await_go();
    finish(1'h0);
    // Own axis selected, own stop not counted: the start stays held
    wr(`ACSS_OFF_ENV2, 32'h0);
    wr(`ACSS_OFF_MODE, 32'h0);
    launch(1'h0, 1'h0, 1'h0);
    await_go();
    wr(`ACSS_OFF_MODE, 32'h001c_0000);
    launch(1'h0, 1'h0, 1'h0);
    pulse_end(1'h0);
    repeat (20) @(posedge core_clk);
    #1;
    chk("held by own stop", 32'h4, {28'h0, operatingStatus});
    $display("test sync start done");
    end_of_test();
  end
endmodule
`default_nettype wire
